// ==== include/sram_ctrl_pkg.sv ====
// Package: constants and carrier types for the static memory controller
package sram_ctrl_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W    = 18;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned LANE_W    = 8;
  localparam int unsigned WORDS     = 262144;

  // ----------------------------------------------------------------
  // Timing (clock 20 MHz, 50 ns period)
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Strobe low time needed to end a write (slowest grade)
  localparam int unsigned WR_PULSE_NS   = 10;
  // Output enable high before strobe falls to free the bus
  localparam int unsigned OE_FREE_NS    = 4;
  // Address access time before read data is sampled (slowest grade)
  localparam int unsigned ACCESS_NS     = 15;
  localparam int unsigned WR_PULSE_CYC  =
    (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned OE_FREE_CYC   =
    (OE_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACCESS_CYC    =
    (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  CNT_ONE       = 2'h1;

  // ----------------------------------------------------------------
  // Reset values of the memory pins (all inactive)
  // ----------------------------------------------------------------
  localparam logic        PIN_IDLE      = 1'b1;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] word_index;
    logic [1:0]        lane_en;
    logic [DATA_W-1:0] wdata;
  } req_t;

  typedef struct packed {
    logic              chip_sel_n;
    logic              out_en_n;
    logic              wr_strobe_n;
    logic              low_lane_sel_n;
    logic              high_lane_sel_n;
  } ctl_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_RD    = 3'b001,
    ST_WFREE = 3'b010,
    ST_WR    = 3'b011,
    ST_WEND  = 3'b100
  } state_t;

endpackage : sram_ctrl_pkg

// ==== design/sram_ctrl.sv ====
// Controller that drives an asynchronous 256K x 16 static memory
`timescale 1ns/1ns
// ------------------------------------------------------------------
// What this block does
// RULE1: Memory holds 262144 words of two byte lanes
// RULE2: Deselected chip ignores inputs and floats data
// RULE3: Write strobe level chooses write or read
// RULE4: Separate low and high lane selects
// RULE5: Read drives only selected lanes
// RULE6: Strobe stays high through every read
// RULE7: Raise output enable before write frees bus
// RULE8: Store only while select, strobe, lane overlap
// RULE9: First deasserting signal ends the store
// RULE10: Hold data stable around terminating edge
// RULE11: Write changes only selected lanes
// RULE12: Lane-select pulses may frame each write
// RULE13: Writes valid whatever output enable level
// RULE14: Falling strobe makes memory release data
// RULE15: Rising strobe lets memory drive again
// RULE16: Continuous read follows address changes
// RULE17: Address valid no later than select falls
// RULE18: Contents kept without clock or refresh
// RULE19: Select and strobe inactive during reset
// ------------------------------------------------------------------
module sram_ctrl
  import sram_ctrl_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  // User request side
  input  wire logic              req_valid_in,
  input  wire req_t              req_in,
  output logic                   req_ready_out,
  output logic                   rd_valid_out,
  output logic [DATA_W-1:0]      rd_data_out,
  // Memory pins
  output logic [ADDR_W-1:0]      word_index_out,
  output ctl_t                   ctl_out,
  input  wire logic [DATA_W-1:0] data_pins_in,
  output logic [DATA_W-1:0]      data_pins_out,
  output logic [1:0]             data_pins_oe_out
);

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  state_t            state_ff;
  state_t            nxt_state;
  logic [1:0]        cnt_ff;
  logic [1:0]        nxt_cnt;
  logic [1:0]        lane_ff;
  logic [DATA_W-1:0] pin_s1_ff;
  logic [DATA_W-1:0] pin_s2_ff;
  logic              take;

  assign take = req_valid_in && req_ready_out;

  // ----------------------------------------------------------------
  // Pin input synchroniser
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_s1_ff <= '0;
      pin_s2_ff <= '0;
    end else begin
      pin_s1_ff <= data_pins_in;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (take) begin
          nxt_cnt = CNT_ONE;
          // Output enable is already high at idle, so it frees the bus first
          nxt_state = req_in.write ? ST_WFREE : ST_RD; // RULE7 RULE3
        end
      end
      ST_RD: begin
        // Wait for access time plus the two-stage synchroniser
        if (cnt_ff == 2'(ACCESS_CYC + 2)) begin
          nxt_state = ST_IDLE;
        end else begin
          nxt_cnt = cnt_ff + CNT_ONE;
        end
      end
      ST_WFREE: begin
        if (cnt_ff >= 2'(OE_FREE_CYC)) begin
          nxt_cnt   = CNT_ONE;
          nxt_state = ST_WR;
        end else begin
          nxt_cnt = cnt_ff + CNT_ONE;
        end
      end
      ST_WR: begin
        if (cnt_ff >= 2'(WR_PULSE_CYC)) begin
          nxt_state = ST_WEND;
        end else begin
          nxt_cnt = cnt_ff + CNT_ONE;
        end
      end
      ST_WEND: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_ff <= ST_IDLE;
      cnt_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Address, data and lane registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      word_index_out <= '0;
      data_pins_out  <= '0;
      lane_ff        <= '0;
    end else if (take) begin
      // Address is set the same edge select falls
      word_index_out <= req_in.word_index; // RULE17 RULE1
      data_pins_out  <= req_in.wdata;
      lane_ff        <= req_in.lane_en;
    end
  end

  // ----------------------------------------------------------------
  // Memory control pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl_out <= '{PIN_IDLE, PIN_IDLE, PIN_IDLE, PIN_IDLE, PIN_IDLE}; // RULE19
    end else begin
      ctl_out.chip_sel_n      <= !(nxt_state != ST_IDLE); // RULE2
      ctl_out.out_en_n        <= !(nxt_state == ST_RD); // RULE13
      // Strobe only in the write pulse; high through reads
      ctl_out.wr_strobe_n     <= !(nxt_state == ST_WR); // RULE6 RULE8
      // Write lanes drop after select, rise one cycle before select ends
      ctl_out.low_lane_sel_n  <= !((nxt_state == ST_RD || nxt_state == ST_WR)
                                   && (take ? req_in.lane_en[0] : lane_ff[0])); // RULE4 RULE12
      ctl_out.high_lane_sel_n <= !((nxt_state == ST_RD || nxt_state == ST_WR)
                                   && (take ? req_in.lane_en[1] : lane_ff[1])); // RULE11
    end
  end

  // ----------------------------------------------------------------
  // Data pin drive: held one cycle past strobe rise
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      data_pins_oe_out <= '0;
    end else begin
      data_pins_oe_out <= (nxt_state == ST_WR || nxt_state == ST_WEND) ? lane_ff : 2'h0; // RULE10
    end
  end

  // ----------------------------------------------------------------
  // User handshake and read return
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      req_ready_out <= 1'b0;
      rd_valid_out  <= 1'b0;
      rd_data_out   <= '0;
    end else begin
      req_ready_out <= (nxt_state == ST_IDLE) && !take;
      rd_valid_out  <= (state_ff == ST_RD) && (nxt_state == ST_IDLE);
      if ((state_ff == ST_RD) && (nxt_state == ST_IDLE)) begin
        rd_data_out <= pin_s2_ff; // RULE5
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  strobe_in_read_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !ctl_out.out_en_n |-> ctl_out.wr_strobe_n) // RULE6
    else $error("strobe low while output enable low");

  oe_free_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $fell(ctl_out.wr_strobe_n) |-> $past(ctl_out.out_en_n) && !ctl_out.chip_sel_n) // RULE7
    else $error("bus not freed before write strobe");

  data_hold_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(ctl_out.wr_strobe_n) |-> $stable(data_pins_out) && data_pins_oe_out ==
      ~{$past(ctl_out.high_lane_sel_n), $past(ctl_out.low_lane_sel_n)}) // RULE10
    else $error("write data not held across strobe rise");

  write_overlap_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !ctl_out.wr_strobe_n |-> !ctl_out.chip_sel_n
      && data_pins_oe_out == ~{ctl_out.high_lane_sel_n, ctl_out.low_lane_sel_n}) // RULE11
    else $error("write overlap or lane drive mismatch");

  lane_end_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(ctl_out.wr_strobe_n) |=> ctl_out.chip_sel_n) // RULE9
    else $error("select not released after write");

  addr_stable_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    !ctl_out.chip_sel_n && !$past(ctl_out.chip_sel_n) |-> $stable(word_index_out)) // RULE17
    else $error("address changed while selected");

  read_return_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    take && !req_in.write |-> ##4 rd_valid_out) // RULE5
    else $error("read data not returned in time");

  idle_pins_a: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ctl_out.chip_sel_n |-> ctl_out.wr_strobe_n && ctl_out.out_en_n) // RULE2
    else $error("strobe or output enable active while deselected");

endmodule // sram_ctrl

// ==== tb/sram_model.sv ====
// Behavioural model of the asynchronous 256K x 16 static memory
`timescale 1ns/1ns
module sram_model
  import sram_ctrl_pkg::*;
(
  // Memory pins
  input  wire logic [ADDR_W-1:0] word_index_in,
  input  wire ctl_t              ctl_in,
  input  wire logic [DATA_W-1:0] bus_in,
  // Memory drive onto the data lanes
  output logic [DATA_W-1:0]      data_out,
  output logic [1:0]             drive_out
);
  logic [DATA_W-1:0] mem [WORDS];
  logic [1:0]        sel;
  logic [1:0]        store;

  assign sel = ~{ctl_in.high_lane_sel_n, ctl_in.low_lane_sel_n};
  assign store = (!ctl_in.chip_sel_n && !ctl_in.wr_strobe_n) ? sel : 2'h0;

  // Each lane takes its byte at the edge that ends its overlap
  always @(negedge store[0]) begin
    if ($time > 0) mem[word_index_in][7:0] = bus_in[7:0];
  end
  always @(negedge store[1]) begin
    if ($time > 0) mem[word_index_in][15:8] = bus_in[15:8];
  end

  assign drive_out = (!ctl_in.chip_sel_n && ctl_in.wr_strobe_n && !ctl_in.out_en_n) ? sel
                   : 2'h0;
  assign data_out = mem[word_index_in];
endmodule // sram_model

// ==== tb/testbench.sv ====
// Testbench: memory controller against a behavioural static memory
`timescale 1ns/1ns
module testbench
  import sram_ctrl_pkg::*;
;
  logic              clk_in = 1'b0;
  logic              rst_b_in = 1'b0;
  logic              req_valid_in = 1'b0;
  req_t              req_in = '0;
  logic              req_ready_out;
  logic              rd_valid_out;
  logic [DATA_W-1:0] rd_data_out, pins, pins_out, m_data;
  logic [DATA_W-1:0] last = 16'h0000;
  logic [ADDR_W-1:0] word_index_out;
  ctl_t              ctl_out;
  logic [1:0]        oe, m_drv;
  int                failures = 0;
  int                checks_done = 0;
  int                cycles = 0;

  always #25 clk_in = ~clk_in;

  sram_ctrl dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .req_valid_in(req_valid_in),
    .req_in(req_in), .req_ready_out(req_ready_out), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .word_index_out(word_index_out), .ctl_out(ctl_out),
    .data_pins_in(pins), .data_pins_out(pins_out), .data_pins_oe_out(oe));
  sram_model mem (.word_index_in(word_index_out), .ctl_in(ctl_out), .bus_in(pins),
    .data_out(m_data), .drive_out(m_drv));

  // Undriven lanes float to the inverse of their last level
  assign pins = {oe[1] ? pins_out[15:8] : m_drv[1] ? m_data[15:8] : ~last[15:8],
                 oe[0] ? pins_out[7:0] : m_drv[0] ? m_data[7:0] : ~last[7:0]};
  always @(posedge clk_in) last <= pins;

  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic close_out();
    if (failures == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One request, held from a falling edge until the falling edge after the edge that takes it
  task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [1:0] ln,
                       input logic [DATA_W-1:0] d);
    @(negedge clk_in);
    req_in = '{write: wr, word_index: a, lane_en: ln, wdata: d};
    req_valid_in = 1'b1;
    while (req_ready_out !== 1'b1) @(negedge clk_in);
    @(posedge clk_in);
    @(negedge clk_in);
    req_valid_in = 1'b0;
  endtask

  task automatic read_chk(input logic [ADDR_W-1:0] a, input logic [1:0] ln,
                          input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] msk);
    issue(1'b0, a, ln, 16'h0000);
    repeat (3) @(negedge clk_in);
    check(rd_valid_out === 1'b1, "read answer missing");
    check(word_index_out === a, "read address wrong");
    check((rd_data_out & msk) === (exp & msk), "read data wrong");
  endtask

  task automatic t_reset();
    check(ctl_out === 5'h1F, "pins active in reset");
    check(oe === 2'h0, "data driven in reset");
  endtask

  task automatic t_edges();
    issue(1'b1, 18'h00000, 2'h3, 16'hA55A);
    issue(1'b1, 18'h3FFFF, 2'h3, 16'h1234);
    read_chk(18'h00000, 2'h3, 16'hA55A, 16'hFFFF);
    read_chk(18'h3FFFF, 2'h3, 16'h1234, 16'hFFFF);
  endtask

  task automatic t_lanes();
    issue(1'b1, 18'h00005, 2'h3, 16'hFFFF);
    issue(1'b1, 18'h00005, 2'h1, 16'h00C3);
    read_chk(18'h00005, 2'h3, 16'hFFC3, 16'hFFFF);
    issue(1'b1, 18'h00005, 2'h2, 16'h5A00);
    issue(1'b1, 18'h00005, 2'h0, 16'h0000);
    read_chk(18'h00005, 2'h3, 16'h5AC3, 16'hFFFF);
    read_chk(18'h00005, 2'h2, 16'h5A00, 16'hFF00);
    read_chk(18'h00005, 2'h1, 16'h00C3, 16'h00FF);
  endtask

  // Pin discipline watched on every cycle out of reset
  always @(negedge clk_in) begin
    if (rst_b_in) begin
      check((ctl_out.out_en_n | ctl_out.wr_strobe_n) === 1'b1, "strobe low in read");
      check(oe === 2'h0 || ctl_out.out_en_n === 1'b1, "bus fight");
    end
  end

  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      $display("[FAIL] %0t run hung", $time);
      close_out();
    end
  end

  initial begin
    repeat (16) @(negedge clk_in);
    t_reset();
    rst_b_in = 1'b1;
    t_edges();
    t_lanes();
    close_out();
  end
endmodule // testbench
